// File: rtl/tx_cmd_decoder.sv
/*
 * transmit buffer command decoder: takes the word stream the host writes to the
 * transmit data port, parses both command words, strips start offset and end
 * padding, and forwards valid words with byte lanes; checks packet length.
 * assumes an apb master on pclk and a sink that accepts a word every cycle.
 */
// Decided for this implementation: the APB interface to the registers and the address map.
// Notes on behaviour
// - drop trailing dwords up to the alignment boundary
// - start offset 0..31 skips leading bytes
// - first segment flag restarts packet tracking
// - last segment flag closes packet after data
// - buffer size field delimits the buffer
// - summed buffer sizes must match packet length
// - completion request flags buffer fully loaded
// - second command word identical across packet
// - packet length sits in low eleven bits
// - low offset bits pick first byte lane
`timescale 1ns/1ps
module tx_cmd_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output tx_cmd_pkg::word_out_type out_word,
  output logic out_valid,
  output logic transmit_error_flag,
  output logic tx_buffer_loaded_flag,
  output logic irq
);

  // every register of the block lives in this one struct, so reset and update stay in one place
  typedef struct packed {
    tx_cmd_pkg::phase_type phase;
    tx_cmd_pkg::cmd_a_type cmd_a;
    tx_cmd_pkg::cmd_b_type cmd_b;
    logic pkt_open;
    logic [15:0] acc;
    logic [9:0] widx;
    logic [1:0] status;
    logic [1:0] mask;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    tx_cmd_pkg::word_out_type word;
    logic valid;
    logic irq;
  } state_type;

  state_type s_q;
  state_type s_d;
  tx_cmd_pkg::geom_type geom;

  // geometry follows the stored first command word, so it stays steady through the data phase
  tx_cmd_geometry u_geom (
    .cmd(s_q.cmd_a),
    .geom(geom)
  );

  // per-cycle decode helpers, all given a value at the top of the combinational process
  logic access;
  logic wr_data;
  logic [1:0] set_bits;
  logic [1:0] clr_bits;
  logic buf_end;
  logic [3:0] lanes;
  logic [9:0] widx_next;
  tx_cmd_pkg::cmd_a_type new_a;
  tx_cmd_pkg::cmd_b_type new_b;

  always_comb begin
    s_d = s_q;
    set_bits = 2'h0;
    clr_bits = 2'h0;
    buf_end = 1'b0;
    lanes = 4'hf;
    widx_next = s_q.widx + 10'h001;
    new_a = tx_cmd_pkg::cmd_a_type'(pwdata);
    new_b = tx_cmd_pkg::cmd_b_type'(pwdata);
    s_d.valid = 1'b0;
    s_d.word.last = 1'b0;

    // apb: ready one cycle into the access phase, acted on at the edge it is sampled
    access = psel && penable && s_q.ready;
    s_d.ready = psel && penable && !s_q.ready;
    s_d.slverr = 1'b0;
    s_d.rdata = 32'h0000_0000;
    wr_data = access && pwrite && (paddr == tx_cmd_pkg::ADDR_TX_DATA);
    if (psel && penable && !s_q.ready) begin
      case (paddr)
        tx_cmd_pkg::ADDR_TX_DATA: s_d.rdata = 32'h0000_0000; // write-only port
        tx_cmd_pkg::ADDR_STATUS: s_d.rdata = {30'h0000_0000, s_q.status};
        tx_cmd_pkg::ADDR_MASK: s_d.rdata = {30'h0000_0000, s_q.mask};
        tx_cmd_pkg::ADDR_INFO: s_d.rdata = {13'h0000, s_q.pkt_open, s_q.phase, s_q.acc};
        default: s_d.slverr = 1'b1;
      endcase
    end
    if (access && pwrite && paddr == tx_cmd_pkg::ADDR_STATUS) begin
      clr_bits = pwdata[1:0];
    end
    if (access && pwrite && paddr == tx_cmd_pkg::ADDR_MASK) begin
      s_d.mask = pwdata[1:0];
    end

    // word stream parser
    // no back-pressure: a forwarded word stands one cycle and a stalled sink loses it
    case (s_q.phase)
      tx_cmd_pkg::PH_CMD_A: begin
        if (wr_data) begin
          s_d.cmd_a = new_a;
          s_d.phase = tx_cmd_pkg::PH_CMD_B;
          s_d.widx = tx_cmd_pkg::WIDX_RESET;
          if (new_a.end_align == tx_cmd_pkg::ALIGN_RSVD) begin
            set_bits[tx_cmd_pkg::STAT_ERR] = 1'b1; // reserved alignment cannot be stripped
          end
          // a first segment restarts the sum even if the previous packet was never closed
          if (new_a.first_seg) begin
            s_d.acc = {5'h00, new_a.buf_size};
            s_d.pkt_open = 1'b1;
          end else begin
            s_d.acc = s_q.acc + {5'h00, new_a.buf_size};
            if (!s_q.pkt_open) begin
              set_bits[tx_cmd_pkg::STAT_ERR] = 1'b1; // continuation without an opening buffer
            end
          end
        end
      end
      tx_cmd_pkg::PH_CMD_B: begin
        if (wr_data) begin
          s_d.cmd_b = new_b;
          s_d.phase = tx_cmd_pkg::PH_DATA;
          // the first buffer only loads the reference word; later buffers must repeat it
          if (!s_q.cmd_a.first_seg && new_b != s_q.cmd_b) begin
            set_bits[tx_cmd_pkg::STAT_ERR] = 1'b1;
          end
          buf_end = (geom.pad_words == 10'h000); // empty buffer ends here
        end
      end
      tx_cmd_pkg::PH_DATA: begin
        if (wr_data) begin
          if (s_q.widx == {7'h00, geom.skip_words}) begin
            lanes = lanes & geom.first_lanes;
          end
          if (widx_next == geom.data_words) begin
            lanes = lanes & geom.last_lanes;
          end
          // leading offset dwords and trailing padding are dropped
          if (s_q.widx >= {7'h00, geom.skip_words} && s_q.widx < geom.data_words && lanes != 4'h0) begin
            s_d.valid = 1'b1;
            s_d.word.data = pwdata;
            s_d.word.lanes = lanes;
            s_d.word.last = s_q.cmd_a.last_seg && (widx_next == geom.data_words);
          end
          // the index counts every written dword, offset and padding included
          s_d.widx = widx_next;
          buf_end = (widx_next == geom.pad_words);
        end
      end
      default: begin
        s_d.phase = tx_cmd_pkg::PH_CMD_A;
      end
    endcase

    // end of one buffer: completion flag and packet length check
    if (buf_end) begin
      s_d.phase = tx_cmd_pkg::PH_CMD_A;
      if (s_q.cmd_a.done_irq) begin
        set_bits[tx_cmd_pkg::STAT_LOADED] = 1'b1;
      end
      // the sum already holds this buffer; it is held against the stored second word
      if (s_q.cmd_a.last_seg) begin
        s_d.pkt_open = 1'b0;
        if (s_d.acc != {5'h00, s_d.cmd_b.pkt_len}) begin
          set_bits[tx_cmd_pkg::STAT_ERR] = 1'b1;
        end
      end
    end

    // a new event in the clearing cycle survives
    s_d.status = (s_q.status & ~clr_bits) | set_bits;
    s_d.irq = |(s_d.status & s_d.mask);
  end

  // single state register; reset is asynchronous and its release is taken on pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{
        phase: tx_cmd_pkg::PH_CMD_A,
        cmd_a: '0,
        cmd_b: '0,
        pkt_open: 1'b0,
        acc: tx_cmd_pkg::ACC_RESET,
        widx: tx_cmd_pkg::WIDX_RESET,
        status: tx_cmd_pkg::STATUS_RESET,
        mask: tx_cmd_pkg::MASK_RESET,
        rdata: 32'h0000_0000,
        ready: 1'b0,
        slverr: 1'b0,
        word: '0,
        valid: 1'b0,
        irq: 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  // all outputs straight from the state register
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.slverr;
  assign out_word = s_q.word;
  assign out_valid = s_q.valid;
  assign transmit_error_flag = s_q.status[tx_cmd_pkg::STAT_ERR];
  assign tx_buffer_loaded_flag = s_q.status[tx_cmd_pkg::STAT_LOADED];
  assign irq = s_q.irq;

endmodule

// File: include/tx_cmd_pkg.sv
/*
 * shared types and constants of the transmit buffer command decoder:
 * command word layouts, buffer geometry, register map, reset values.
 * assumes a 32-bit word stream and an apb register port.
 */
package tx_cmd_pkg;

  // register map, byte addresses on apb
  localparam logic [7:0] ADDR_TX_DATA = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_INFO = 8'h0c;

  // status and mask bit positions
  localparam int unsigned STAT_W = 2;
  localparam int unsigned STAT_ERR = 0;
  localparam int unsigned STAT_LOADED = 1;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [15:0] ACC_RESET = 16'h0000;
  localparam logic [9:0] WIDX_RESET = 10'h000;

  // end alignment codes
  localparam logic [1:0] ALIGN_4 = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  localparam logic [1:0] ALIGN_RSVD = 2'h3;
  localparam logic [12:0] ALIGN_MASK_4 = 13'h0003;
  localparam logic [12:0] ALIGN_MASK_16 = 13'h000f;
  localparam logic [12:0] ALIGN_MASK_32 = 13'h001f;

  typedef struct packed {
    logic done_irq;        // 31
    logic [4:0] rsvd_hi;   // 30:26
    logic [1:0] end_align; // 25:24
    logic [2:0] rsvd_a;    // 23:21
    logic [4:0] start_off; // 20:16
    logic [1:0] rsvd_b;    // 15:14
    logic first_seg;       // 13
    logic last_seg;        // 12
    logic rsvd_c;          // 11
    logic [10:0] buf_size; // 10:0
  } cmd_a_type;

  typedef struct packed {
    logic [15:0] tag;
    logic [1:0] rsvd_a;
    logic crc_off;
    logic pad_off;
    logic rsvd_b;
    logic [10:0] pkt_len;
  } cmd_b_type;

  typedef struct packed {
    logic [2:0] skip_words;  // whole dwords before the first valid byte
    logic [9:0] data_words;  // dwords up to and holding the last valid byte
    logic [9:0] pad_words;   // dwords the host writes, padding included
    logic [3:0] first_lanes;
    logic [3:0] last_lanes;
  } geom_type;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] lanes;
    logic last;
  } word_out_type;

  typedef enum logic [1:0] {
    PH_CMD_A = 2'b00,
    PH_CMD_B = 2'b01,
    PH_DATA = 2'b10
  } phase_type;

endpackage

// File: rtl/tx_cmd_geometry.sv
/*
 * works out the dword layout of one transmit buffer from its first command word.
 * purely combinational; the caller holds the command word in a register.
 */
`timescale 1ns/1ps
module tx_cmd_geometry (
  input wire tx_cmd_pkg::cmd_a_type cmd,
  output tx_cmd_pkg::geom_type geom
);

  logic [12:0] end_byte;
  logic [12:0] align_mask;
  logic [12:0] padded;
  logic [12:0] used_words;

  // end of valid data, then rounded up to the host's burst boundary
  always_comb begin
    end_byte = {2'b00, cmd.buf_size} + {8'h00, cmd.start_off};
    case (cmd.end_align)
      tx_cmd_pkg::ALIGN_4: align_mask = tx_cmd_pkg::ALIGN_MASK_4;
      tx_cmd_pkg::ALIGN_16: align_mask = tx_cmd_pkg::ALIGN_MASK_16;
      tx_cmd_pkg::ALIGN_32: align_mask = tx_cmd_pkg::ALIGN_MASK_32;
      default: align_mask = tx_cmd_pkg::ALIGN_MASK_4; // reserved code, flagged by the caller
    endcase
    padded = (end_byte + align_mask) & ~align_mask;
    used_words = (end_byte + 13'h0003) >> 2;
    geom.skip_words = cmd.start_off[4:2];
    geom.data_words = used_words[9:0];
    geom.pad_words = padded[11:2];
    geom.first_lanes = 4'hf << cmd.start_off[1:0];
    geom.last_lanes = ~(4'hf << end_byte[1:0]);
    if (end_byte[1:0] == 2'h0) begin
      geom.last_lanes = 4'hf;
    end
  end

endmodule

// File: tb/tx_cmd_decoder_checker.sv
/* port assertions for the transmit command decoder.
   assumes one clock pclk and the active-low reset presetn. */
`timescale 1ns/1ps
module tx_cmd_decoder_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire tx_cmd_pkg::word_out_type out_word,
  input wire logic out_valid,
  input wire logic transmit_error_flag,
  input wire logic tx_buffer_loaded_flag,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a completed write to the data port is the only cause of stream activity
  logic wr_data;
  assign wr_data = psel && penable && pready && pwrite && paddr == tx_cmd_pkg::ADDR_TX_DATA;
  access_two_a: assert property (psel && $rose(penable) |-> !pready ##1 pready) else $error("access length");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  refusal_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad refusal");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
  out_cause_a: assert property (out_valid |-> $past(wr_data)) else $error("word without write");
  out_lanes_a: assert property (out_valid |-> out_word.lanes != 4'h0) else $error("empty word");
  err_cause_a: assert property ($rose(transmit_error_flag) |-> $past(wr_data)) else $error("error cause");
  loaded_cause_a: assert property ($rose(tx_buffer_loaded_flag) |-> $past(wr_data)) else $error("loaded cause");
  irq_quiet_a: assert property ((!transmit_error_flag && !tx_buffer_loaded_flag) [*2] |-> !irq)
    else $error("irq without status");
endmodule

bind tx_cmd_decoder tx_cmd_decoder_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .out_word(out_word), .out_valid(out_valid), .transmit_error_flag(transmit_error_flag),
  .tx_buffer_loaded_flag(tx_buffer_loaded_flag), .irq(irq));

// File: tb/tx_host_model.sv
/* host cpu model: apb master writing command words and buffers.
   assumes the decoder answers each access with pready on pclk. */
`timescale 1ns/1ps
module tx_host_model (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // request held until pready is sampled high, then released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  // one buffer; np is the padded word count the host chose
  task automatic buf_send(input logic [1:0] al, input logic [4:0] off, input logic [10:0] sz,
                          input logic [1:0] fl, input logic [31:0] cb, input int np);
    logic [31:0] r;
    logic e;
    tx_cmd_pkg::cmd_a_type ca;
    ca = '0;
    {ca.done_irq, ca.end_align, ca.start_off} = {1'b1, al, off};
    {ca.first_seg, ca.last_seg, ca.buf_size} = {fl, sz};
    xfer(1'b1, tx_cmd_pkg::ADDR_TX_DATA, ca, r, e);
    xfer(1'b1, tx_cmd_pkg::ADDR_TX_DATA, cb, r, e);
    for (int i = 0; i < np; i++) xfer(1'b1, tx_cmd_pkg::ADDR_TX_DATA, 32'h5a000000 + i, r, e);
  endtask
endmodule

// File: tb/test_tx_buffer_command_decoder.sv
/* self-checking bench for the transmit command decoder.
   assumes the sink takes a word every cycle; host model drives apb. */
`timescale 1ns/1ps
module test_tx_buffer_command_decoder;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, out_valid, terr, loaded, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  tx_cmd_pkg::word_out_type out_word;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [36:0] seen[$];
  logic [36:0] exp[$];
  always #20 pclk = ~pclk;
  tx_host_model u_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  tx_cmd_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .out_word(out_word), .out_valid(out_valid), .transmit_error_flag(terr),
    .tx_buffer_loaded_flag(loaded), .irq(irq));
  // out_valid stands one cycle, so every edge is looked at
  always @(posedge pclk) if (out_valid === 1'b1) seen.push_back(out_word);
  task automatic check(input logic [36:0] got, input logic [36:0] want);
    num_checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want, input logic we);
    logic [31:0] r;
    logic e;
    u_host.xfer(1'b0, a, 32'h0, r, e);
    check({4'h0, e, r}, {4'h0, we, want});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    u_host.xfer(1'b1, a, d, r, e);
  endtask
  // expected words worked out from offset and size; alignment only sets the padded count
  task automatic pkt(input logic [1:0] al, input int off, input int sz, input logic [1:0] fl, input int len);
    int e, a, lo, hi;
    logic [3:0] ln;
    a = al == 2'h1 ? 16 : al == 2'h2 ? 32 : 4;
    e = off + sz;
    lo = off / 4;
    hi = (e - 1) / 4;
    for (int i = lo; i <= hi && sz != 0; i++) begin
      ln = 4'hf << (i == lo ? off % 4 : 0);
      if (i == hi && e % 4 != 0) ln &= ~(4'hf << e % 4);
      exp.push_back({32'h5a000000 + i, ln, fl[0] && i == hi});
    end
    u_host.buf_send(al, 5'(off), 11'(sz), fl, {21'h0, 11'(len)}, (e + a - 1) / a * a / 4);
    repeat (2) @(posedge pclk);
  endtask
  task automatic flush(input logic cmp);
    if (cmp) check(37'(seen.size()), 37'(exp.size()));
    foreach (exp[i]) if (cmp && i < seen.size()) check(seen[i], exp[i]);
    seen.delete();
    exp.delete();
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h04, 32'h0, 1'b0);
    rd(8'h08, 32'h0, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    wr(8'h08, 32'h3);
    pkt(2'h0, 1, 5, 2'b11, 5);
    rd(8'h04, 32'h2, 1'b0);
    check({36'h0, irq}, 37'h1);
    check({36'h0, loaded}, 37'h1);
    wr(8'h04, 32'h2);
    // flag and interrupt fall at the clearing edge, so look one edge later
    @(posedge pclk);
    check({36'h0, loaded}, 37'h0);
    check({36'h0, irq}, 37'h0);
    for (int k = 0; k < 3; k++) pkt(2'(k), 6, 9, 2'b11, 9);
    pkt(2'h2, 31, 1, 2'b11, 1);
    pkt(2'h0, 3, 3, 2'b10, 7);
    rd(8'h0c, 32'h0004_0003, 1'b0);
    pkt(2'h0, 0, 4, 2'b01, 7);
    flush(1'b1);
    rd(8'h04, 32'h2, 1'b0);
    wr(8'h04, 32'h3);
    pkt(2'h0, 0, 4, 2'b11, 5);
    check({36'h0, terr}, 37'h1);
    wr(8'h04, 32'h3);
    pkt(2'h0, 0, 4, 2'b10, 8);
    pkt(2'h0, 0, 4, 2'b01, 9);
    rd(8'h04, 32'h3, 1'b0);
    wr(8'h04, 32'h3);
    pkt(2'h3, 0, 4, 2'b11, 4);
    rd(8'h04, 32'h3, 1'b0);
    rd(8'h0c, 32'h0000_0004, 1'b0);
    flush(1'b0);
    results;
  end
  // run needs about three hundred cycles; this cuts a hang short
  initial begin
    #400000;
    n_mismatch++;
    results;
  end
endmodule
